/* File: logic/cpc_map.vh */
// Functional notes
// R1: Only the selected pair raises match.
// R2: Selector 01: home vs actual or encoder.
// R3: Selector 10: position vs its latch.
// R4: Selector 11: turns vs compare value.
// R5: Selector 00: compare value vs position.
// R6: Zero at target, restart if target nonzero.
// R7: Target changes allowed; zero on equality.
// R8: Software sets range first, position inside.
// R9: Circular keeps position in half range.
// R10: Wrap loads opposite range limit.
// R11: Circular positioning takes shortest path.
// R12: Fraction 1.31 added each revolution.
// R13: Accumulator overflow holds wrap one step.
// R14: Turns count up/down on wraps.
// R15: Shared address reads latch or turns.
// R16: Turns forced zero without circular motion.
// R17: Path planned around blocking zone. The code plans it only with circular on and both limits enabled.
// R18: Deceleration starts at either zone limit.
// R19: Lower below upper: either condition blocks.
// R20: Lower above upper: both conditions block.
// R21: Comparison evaluated every clock cycle.
`ifndef CPC_MAP_VH
`define CPC_MAP_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define CPC_IDX_GLOBAL     7'h00
`define CPC_IDX_SWITCH     7'h01
`define CPC_IDX_HOME       7'h16
`define CPC_IDX_RAMP_KIND  7'h20
`define CPC_IDX_ACTUAL     7'h21
`define CPC_IDX_COMPARE    7'h32
`define CPC_IDX_LOWER      7'h33
`define CPC_IDX_UPPER      7'h34
`define CPC_IDX_RANGE      7'h36
`define CPC_IDX_TARGET     7'h37
`define CPC_IDX_FRACTION   7'h7C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CPC_GS_SHOW_TURNS  0
`define CPC_SW_CMP_SOURCE  0
`define CPC_SW_CMP_SEL_LO  1
`define CPC_SW_CMP_SEL_HI  2
`define CPC_SW_ZERO_AT_TGT 3
`define CPC_SW_CIRCULAR    4
`define CPC_SW_VSTOP_L_EN  5
`define CPC_SW_VSTOP_R_EN  6
`define CPC_RK_POSITIONING 2

// ------------------------------------------------------------
// Compare selector codes and shared 32-bit constants
// ------------------------------------------------------------
`define CPC_SEL_VALUE      2'h0
`define CPC_SEL_HOME       2'h1
`define CPC_SEL_LATCH      2'h2
`define CPC_SEL_TURNS      2'h3
`define CPC_ZERO32         32'h00000000
`define CPC_ONE32          32'h00000001

`endif

/* File: logic/cpc_position.v */
// The APB interface to the registers is this design's own decision.
`include "cpc_map.vh"
`default_nettype none

module cpc_position (
   input  wire        sys_clk,
   input  wire        rstn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [8:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        step_req,
   input  wire        vel_dir,
   input  wire [31:0] enc_pos,
   input  wire [31:0] enc_latch,
   input  wire        latch_strobe,
   output reg         step_out,
   output reg         dir_out,
   output reg         target_reached,
   output reg         ramp_restart,
   output reg         comp_flag,
   output reg         comp_event,
   output reg         zone_blocked,
   output reg         vstop_decel
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   reg         rst_meta_reg;
   reg         rst_sync_reg;
   wire        rst_n = rst_sync_reg;

   // Asynchronous assert, synchronous release
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   reg  [31:0] global_settings_reg;
   reg  [31:0] switch_settings_reg;
   reg  [31:0] home_position_reg;
   reg  [31:0] ramp_kind_reg;
   reg  [31:0] compare_value_reg;
   reg  [31:0] lower_zone_limit_reg;
   reg  [31:0] upper_zone_limit_reg;
   reg  [31:0] wrap_half_range_reg;
   reg  [31:0] target_position_reg;
   reg  [31:0] fractional_step_extension_reg;
   reg  [31:0] actual_position_reg;
   reg  [31:0] actual_position_next;
   reg  [31:0] latched_position_reg;
   reg  [31:0] turns_reg;
   reg  [31:0] turns_next;
   reg  [31:0] frac_acc_reg;
   reg  [31:0] frac_acc_next;
   // Extra steps still owed after a fractional carry, up to two per wrap
   reg  [1:0]  hold_reg;
   reg  [1:0]  hold_next;
   reg         moved_next;
   reg         dir_next;
   reg         restart_next;
   reg         match_prev_reg;

   wire [6:0]  idx       = paddr[8:2];
   wire        wr_access = psel & penable & pready & pwrite;
   wire        circ      = switch_settings_reg[`CPC_SW_CIRCULAR];
   wire        positioning = ramp_kind_reg[`CPC_RK_POSITIONING];
   wire        circ_on   = circ & (wrap_half_range_reg != `CPC_ZERO32);
   wire        act_wr    = wr_access & (idx == `CPC_IDX_ACTUAL);
   wire        l_en      = switch_settings_reg[`CPC_SW_VSTOP_L_EN];
   wire        r_en      = switch_settings_reg[`CPC_SW_VSTOP_R_EN];

   // Address decode; unmapped indices answer with an error
   reg         mapped;
   reg  [31:0] rd_mux;
   always @* begin
      mapped = 1'b1;
      rd_mux = `CPC_ZERO32;
      case (idx)
         `CPC_IDX_GLOBAL:    rd_mux = global_settings_reg;
         `CPC_IDX_SWITCH:    rd_mux = switch_settings_reg;
         `CPC_IDX_HOME:      rd_mux = home_position_reg;
         `CPC_IDX_RAMP_KIND: rd_mux = ramp_kind_reg;
         `CPC_IDX_ACTUAL:    rd_mux = actual_position_reg;
         `CPC_IDX_COMPARE:   rd_mux = compare_value_reg;
         `CPC_IDX_LOWER:     rd_mux = lower_zone_limit_reg;
         `CPC_IDX_UPPER:     rd_mux = upper_zone_limit_reg;
         `CPC_IDX_RANGE:     rd_mux = global_settings_reg[`CPC_GS_SHOW_TURNS] ?
                                      turns_reg : latched_position_reg; // R15
         `CPC_IDX_TARGET:    rd_mux = target_position_reg;
         `CPC_IDX_FRACTION:  rd_mux = fractional_step_extension_reg;
         default:            mapped = 1'b0;
      endcase
   end

   // Answer one cycle after setup; data and error are fixed in setup
   // Read data reflects the state at the setup edge, not at the access edge
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= `CPC_ZERO32;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         if (psel & ~penable) begin
            prdata  <= pwrite ? `CPC_ZERO32 : rd_mux;
            pslverr <= ~mapped;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // Software writes; the range register cannot be read back
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         global_settings_reg           <= `CPC_ZERO32;
         switch_settings_reg           <= `CPC_ZERO32;
         home_position_reg             <= `CPC_ZERO32;
         ramp_kind_reg                 <= `CPC_ZERO32;
         compare_value_reg             <= `CPC_ZERO32;
         lower_zone_limit_reg          <= `CPC_ZERO32;
         upper_zone_limit_reg          <= `CPC_ZERO32;
         wrap_half_range_reg           <= `CPC_ZERO32;
         target_position_reg           <= `CPC_ZERO32;
         fractional_step_extension_reg <= `CPC_ZERO32;
      end else if (wr_access) begin
         case (idx)
            `CPC_IDX_GLOBAL:    global_settings_reg           <= pwdata;
            `CPC_IDX_SWITCH:    switch_settings_reg           <= pwdata;
            `CPC_IDX_HOME:      home_position_reg             <= pwdata;
            `CPC_IDX_RAMP_KIND: ramp_kind_reg                 <= pwdata;
            `CPC_IDX_COMPARE:   compare_value_reg             <= pwdata;
            `CPC_IDX_LOWER:     lower_zone_limit_reg          <= pwdata;
            `CPC_IDX_UPPER:     upper_zone_limit_reg          <= pwdata;
            `CPC_IDX_RANGE:     wrap_half_range_reg           <= pwdata;
            `CPC_IDX_TARGET:    target_position_reg           <= pwdata; // R7
            `CPC_IDX_FRACTION:  fractional_step_extension_reg <= pwdata;
            default:            global_settings_reg           <= global_settings_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Blocking zone
   // ------------------------------------------------------------
   wire signed [31:0] pos_s   = actual_position_reg;
   wire signed [31:0] tgt_s   = target_position_reg;
   wire signed [31:0] low_s   = lower_zone_limit_reg;
   wire signed [31:0] up_s    = upper_zone_limit_reg;
   wire               at_low  = l_en & (pos_s <= low_s);
   wire               at_up   = r_en & (pos_s >= up_s);
   wire               both_en = l_en & r_en;
   wire               split   = both_en & (low_s > up_s);
   // A single enabled limit blocks on its own side only; the inverted
   // form needs both conditions, so it applies only with both limits on
   // Inverted limits block only the band between them
   wire               blocked = split ? (at_low & at_up) : (at_low | at_up); // R19 R20

   // ------------------------------------------------------------
   // Direction choice
   // ------------------------------------------------------------
   // Two spare bits so doubling the range cannot overflow the difference
   wire signed [33:0] half_s  = {2'b00, wrap_half_range_reg};
   wire signed [33:0] diff_s  = {{2{tgt_s[31]}}, tgt_s} - {{2{pos_s[31]}}, pos_s};
   reg  signed [33:0] short_s;
   reg                plan_dir;

   // Shortest signed distance modulo the full range, then zone override
   always @* begin
      short_s = diff_s;
      if (circ_on) begin
         if (diff_s >= half_s) begin
            short_s = diff_s - (half_s <<< 1); // R11
         end else if (diff_s < -half_s) begin
            short_s = diff_s + (half_s <<< 1); // R11
         end
      end
      plan_dir = (short_s > 34'sd0);
      if (circ_on & both_en) begin
         if (!split) begin
            plan_dir = (diff_s > 34'sd0); // R17
         end else if ((pos_s <= up_s) != (tgt_s <= up_s)) begin
            plan_dir = (pos_s > up_s); // R17
         end else begin
            plan_dir = (diff_s > 34'sd0); // R17
         end
      end
   end

   // ------------------------------------------------------------
   // Position stepping
   // ------------------------------------------------------------
   wire [31:0] range_top = wrap_half_range_reg - `CPC_ONE32;
   wire [31:0] range_bot = `CPC_ZERO32 - wrap_half_range_reg;
   wire        at_target = (actual_position_reg == target_position_reg);
   // The extension is one integer bit over 31 fraction bits; the accumulator
   // keeps 32 fraction bits, so the extension enters shifted up by one and the
   // two top bits of the sum count the extra steps owed on this wrap
   wire [33:0] acc_sum   = {2'h0, frac_acc_reg} + {1'b0, fractional_step_extension_reg, 1'b0}; // R12

   // One microstep per request; wrap, hold and zeroing handled here
   always @* begin
      actual_position_next = actual_position_reg;
      turns_next    = turns_reg;
      frac_acc_next = frac_acc_reg;
      hold_next     = hold_reg;
      moved_next    = 1'b0;
      restart_next  = 1'b0;
      dir_next      = positioning ? plan_dir : vel_dir;
      if (positioning & switch_settings_reg[`CPC_SW_ZERO_AT_TGT] & at_target) begin
         actual_position_next = `CPC_ZERO32; // R6 R7
         restart_next = (target_position_reg != `CPC_ZERO32); // R6
      end else if (step_req & ~(positioning & at_target)) begin
         moved_next = 1'b1;
         if (hold_reg != 2'h0) begin
            // Owed step: the position stays put, the request is still consumed
            hold_next = hold_reg - 2'h1; // R13
         end else if (circ_on & dir_next & (actual_position_reg == range_top)) begin
            actual_position_next = range_bot; // R9 R10
            turns_next    = turns_reg + `CPC_ONE32; // R14
            frac_acc_next = acc_sum[31:0];
            hold_next     = acc_sum[33:32]; // R13
         end else if (circ_on & ~dir_next & (actual_position_reg == range_bot)) begin
            actual_position_next = range_top; // R9 R10
            turns_next    = turns_reg - `CPC_ONE32; // R14
            frac_acc_next = acc_sum[31:0];
            hold_next     = acc_sum[33:32]; // R13
         end else if (dir_next) begin
            actual_position_next = actual_position_reg + `CPC_ONE32;
         end else begin
            actual_position_next = actual_position_reg - `CPC_ONE32;
         end
      end
      if (!circ) begin
         turns_next = `CPC_ZERO32; // R16
         hold_next  = 2'h0;
      end
   end

   // Software write to the position wins over a step in the same cycle
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         actual_position_reg <= `CPC_ZERO32;
         turns_reg           <= `CPC_ZERO32;
         frac_acc_reg        <= `CPC_ZERO32;
         hold_reg            <= 2'h0;
         step_out            <= 1'b0;
         dir_out             <= 1'b0;
         ramp_restart        <= 1'b0;
         target_reached      <= 1'b0;
      end else begin
         actual_position_reg <= act_wr ? pwdata : actual_position_next;
         turns_reg           <= turns_next;
         frac_acc_reg        <= frac_acc_next;
         hold_reg            <= hold_next;
         step_out            <= moved_next & ~act_wr;
         dir_out             <= dir_next;
         ramp_restart        <= restart_next;
         target_reached      <= at_target;
      end
   end

   // Position latch on external strobe
   // Only the internal position is latched; the encoder latch arrives ready-made
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_position_reg <= `CPC_ZERO32;
      end else if (latch_strobe) begin
         latched_position_reg <= actual_position_reg;
      end
   end

   // ------------------------------------------------------------
   // Position comparison
   // ------------------------------------------------------------
   wire        src = switch_settings_reg[`CPC_SW_CMP_SOURCE];
   wire [1:0]  sel = switch_settings_reg[`CPC_SW_CMP_SEL_HI:`CPC_SW_CMP_SEL_LO];
   wire [31:0] pos_pick = src ? enc_pos : actual_position_reg;
   reg  [31:0] cmp_a;
   reg  [31:0] cmp_b;

   // Exactly one pair feeds the comparator
   // Under selector 11 the source bit is a don't-care
   always @* begin
      cmp_a = pos_pick;
      cmp_b = compare_value_reg;
      case (sel)
         `CPC_SEL_VALUE: cmp_b = compare_value_reg; // R5
         `CPC_SEL_HOME:  cmp_b = home_position_reg; // R2
         `CPC_SEL_LATCH: cmp_b = src ? enc_latch : latched_position_reg; // R3
         `CPC_SEL_TURNS: cmp_a = turns_reg; // R4
         default:        cmp_b = compare_value_reg;
      endcase
   end

   wire match = (cmp_a == cmp_b); // R1

   // Compared every cycle, so a one-cycle equality is never skipped
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         comp_flag      <= 1'b0;
         comp_event     <= 1'b0;
         match_prev_reg <= 1'b0;
      end else begin
         comp_flag      <= match; // R21
         match_prev_reg <= match;
         comp_event     <= match & ~match_prev_reg; // R1 R21
      end
   end

   // ------------------------------------------------------------
   // Zone status
   // ------------------------------------------------------------
   // Deceleration is requested, never a hard stop; the ramp decides
   // Both lag the position by one cycle, like the compare flag
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         zone_blocked <= 1'b0;
         vstop_decel  <= 1'b0;
      end else begin
         zone_blocked <= blocked;
         vstop_decel  <= (at_low | at_up); // R18
      end
   end

endmodule // cpc_position

`default_nettype wire

/* File: verif/cpc_position_asserts.sv */
`default_nettype none
// ----------------------------------------
// Port checker for the position block
// ----------------------------------------
module cpc_position_asserts (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic step_req,
   input wire logic step_out,
   input wire logic ramp_restart,
   input wire logic comp_flag,
   input wire logic comp_event
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Bus phases; the block answers in the first access cycle
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   a_apb_answer: assert property (s_setup |=> s_access)
      else $error("no answer in the access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_event_rise: assert property ($rose(comp_flag) |-> comp_event)
      else $error("match rose without event");
   a_event_cause: assert property (comp_event |-> comp_flag && !$past(comp_flag))
      else $error("event without a fresh match");
   a_flag_drop: assert property ($fell(comp_flag) |-> !comp_event)
      else $error("event while match falls");
   a_step_cause: assert property (step_out |-> $past(step_req))
      else $error("step output without a request");
   a_restart_pulse: assert property (ramp_restart |=> !ramp_restart)
      else $error("restart longer than one cycle");
endmodule // cpc_position_asserts

bind cpc_position cpc_position_asserts u_chk (
   .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .step_req(step_req), .step_out(step_out), .ramp_restart(ramp_restart),
   .comp_flag(comp_flag), .comp_event(comp_event));
`default_nettype wire

/* File: verif/cpc_host_model.sv */
`default_nettype none
// ----------------------------------------
// Host controller driving the register bus
// ----------------------------------------
module cpc_host_model (
   input  wire logic        sys_clk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [8:0]  paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 9'h000;
      pwdata = 32'h00000000;
   end
   // One transfer; caller enters just after a rising edge
   task automatic xfer(input logic w, input logic [6:0] idx, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // No fixed latency assumed; the bench watchdog ends a hang
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // cpc_host_model
`default_nettype wire

/* File: verif/circular_position_compare_tb_top.sv */
`include "cpc_map.vh"
`default_nettype none
module circular_position_compare_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic [8:0]  paddr;
   logic [31:0] pwdata, prdata, enc_pos, enc_latch;
   logic        step_req, vel_dir, latch_strobe, step_out, dir_out, target_reached;
   logic        ramp_restart, comp_flag, comp_event, zone_blocked, vstop_decel;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          n_restart = 0;
   cpc_host_model u_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   cpc_position DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step_req(step_req), .vel_dir(vel_dir), .enc_pos(enc_pos),
      .enc_latch(enc_latch), .latch_strobe(latch_strobe), .step_out(step_out),
      .dir_out(dir_out), .target_reached(target_reached), .ramp_restart(ramp_restart),
      .comp_flag(comp_flag), .comp_event(comp_event), .zone_blocked(zone_blocked),
      .vstop_decel(vstop_decel));
   // Restart is a one-cycle pulse, so count it as it happens
   always @(posedge sys_clk) if (ramp_restart === 1'b1) n_restart++;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] idx, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      @(posedge sys_clk);
      u_host.xfer(1'b1, idx, d, q, e);
   endtask
   task automatic chk_rd(input string nm, input logic [6:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      @(posedge sys_clk);
      u_host.xfer(1'b0, idx, 32'h00000000, q, e);
      chk(nm, q, exp);
   endtask
   // One step request, then let the outputs settle
   task automatic stp(input logic d);
      @(posedge sys_clk);
      step_req <= 1'b1;
      vel_dir <= d;
      @(posedge sys_clk);
      step_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      chk_rd("compare reset", `CPC_IDX_COMPARE, 32'h00000000);
      wr(`CPC_IDX_LOWER, 32'hA5A5A5A5);
      chk_rd("lower limit", `CPC_IDX_LOWER, 32'hA5A5A5A5);
      @(posedge sys_clk);
      u_host.xfer(1'b0, 7'h7F, 32'h00000000, q, e);
      chk("unmapped error", {31'h0, e}, 32'h00000001);
      chk("unmapped data", q, 32'h00000000);
      $display("register test done");
   endtask
   // Every selector and source; pairs set so the two sources differ except under selector 11
   task automatic t_compare();
      logic [7:0] exp_tbl = 8'h19;
      wr(`CPC_IDX_ACTUAL, 32'h00000005);
      wr(`CPC_IDX_COMPARE, 32'h00000005);
      wr(`CPC_IDX_HOME, 32'h00000007);
      enc_pos <= 32'h00000007;
      enc_latch <= 32'h00000009;
      latch_strobe <= 1'b1;
      @(posedge sys_clk);
      latch_strobe <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         wr(`CPC_IDX_SWITCH, {29'h0, i[2:0]});
         repeat (4) @(posedge sys_clk);
         chk("match flag", {31'h0, comp_flag}, {31'h0, exp_tbl[i]});
      end
      wr(`CPC_IDX_COMPARE, 32'h00000000);
      repeat (4) @(posedge sys_clk);
      chk("turns match", {31'h0, comp_flag}, 32'h00000001);
      $display("compare test done");
   endtask
   task automatic t_circular();
      wr(`CPC_IDX_RAMP_KIND, 32'h00000000);
      wr(`CPC_IDX_GLOBAL, 32'h00000001);
      wr(`CPC_IDX_RANGE, 32'h00000004);
      wr(`CPC_IDX_ACTUAL, 32'h00000003);
      wr(`CPC_IDX_SWITCH, 32'h00000010);
      stp(1'b1);
      chk_rd("wrap up", `CPC_IDX_ACTUAL, 32'hFFFFFFFC);
      chk_rd("turns up", `CPC_IDX_RANGE, 32'h00000001);
      stp(1'b0);
      chk_rd("wrap down", `CPC_IDX_ACTUAL, 32'h00000003);
      chk_rd("turns down", `CPC_IDX_RANGE, 32'h00000000);
      wr(`CPC_IDX_FRACTION, 32'h80000000);
      stp(1'b1);
      stp(1'b1);
      chk_rd("held step", `CPC_IDX_ACTUAL, 32'hFFFFFFFC);
      stp(1'b1);
      chk_rd("after hold", `CPC_IDX_ACTUAL, 32'hFFFFFFFD);
      wr(`CPC_IDX_SWITCH, 32'h00000000);
      chk_rd("turns cleared", `CPC_IDX_RANGE, 32'h00000000);
      wr(`CPC_IDX_GLOBAL, 32'h00000000);
      chk_rd("latch view", `CPC_IDX_RANGE, 32'h00000005);
      $display("circular test done");
   endtask
   task automatic t_target();
      wr(`CPC_IDX_SWITCH, 32'h00000008);
      wr(`CPC_IDX_ACTUAL, 32'h00000000);
      wr(`CPC_IDX_TARGET, 32'h00000002);
      wr(`CPC_IDX_RAMP_KIND, 32'h00000004);
      stp(1'b1);
      stp(1'b1);
      chk("restarts", n_restart, 32'h00000001);
      chk_rd("cleared", `CPC_IDX_ACTUAL, 32'h00000000);
      wr(`CPC_IDX_TARGET, 32'h00000001);
      stp(1'b1);
      chk("new target", n_restart, 32'h00000002);
      // Short way from 200 to -200 crosses the wrap point
      wr(`CPC_IDX_RANGE, 32'h0000012C);
      wr(`CPC_IDX_ACTUAL, 32'h000000C8);
      wr(`CPC_IDX_TARGET, 32'hFFFFFF38);
      wr(`CPC_IDX_SWITCH, 32'h00000010);
      stp(1'b0);
      chk("path dir", {31'h0, dir_out}, 32'h00000001);
      chk_rd("path step", `CPC_IDX_ACTUAL, 32'h000000C9);
      wr(`CPC_IDX_TARGET, 32'h000000C9);
      repeat (2) @(posedge sys_clk);
      chk("reached", {31'h0, target_reached}, 32'h00000001);
      $display("target test done");
   endtask
   task automatic t_zone();
      logic [31:0] lo [5] = '{32'hFFFFFFF6, 32'hFFFFFFF6, 32'hFFFFFFF6, 32'h0000000A, 32'h0000000A};
      logic [31:0] hi [5] = '{32'h0000000A, 32'h0000000A, 32'h0000000A, 32'hFFFFFFF6, 32'hFFFFFFF6};
      logic [31:0] ac [5] = '{32'h00000000, 32'h00000014, 32'hFFFFFFEC, 32'h00000000, 32'h00000014};
      logic [4:0]  ex = 5'b01110;
      wr(`CPC_IDX_RAMP_KIND, 32'h00000000);
      wr(`CPC_IDX_SWITCH, 32'h00000070);
      for (int i = 0; i < 5; i++) begin
         wr(`CPC_IDX_LOWER, lo[i]);
         wr(`CPC_IDX_UPPER, hi[i]);
         wr(`CPC_IDX_ACTUAL, ac[i]);
         repeat (3) @(posedge sys_clk);
         chk("blocked", {31'h0, zone_blocked}, {31'h0, ex[4 - i]});
         if (ex[4 - i]) chk("decel", {31'h0, vstop_decel}, 32'h00000001);
      end
      // From 20 to -20 the direct way crosses the inverted zone, so go round
      wr(`CPC_IDX_TARGET, 32'hFFFFFFEC);
      wr(`CPC_IDX_RAMP_KIND, 32'h00000004);
      repeat (2) @(posedge sys_clk);
      chk("zone path", {31'h0, dir_out}, 32'h00000001);
      $display("zone test done");
   endtask
   // ----------------------------------------
   // Clock, reset, sequence and watchdog
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      rstn = 1'b0;
      step_req = 1'b0;
      vel_dir = 1'b0;
      enc_pos = 32'h00000000;
      enc_latch = 32'h00000000;
      latch_strobe = 1'b0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_regs();
      t_compare();
      t_circular();
      t_target();
      t_zone();
      conclude();
   end
   // All scenarios need a few hundred cycles; this leaves wide margin
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      conclude();
   end
endmodule // circular_position_compare_tb_top
`default_nettype wire
